// ### eeprom_defs.svh
// Constants for the two-wire serial EEPROM slave
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
// Array variants
`define VAR_SMALL      2'h0
`define VAR_MID        2'h1
`define VAR_LARGE      2'h2
`define ADDR_W         9
`define MEM_DEPTH      512
`define MASK_SMALL     9'h07f
`define MASK_MID       9'h0ff
`define MASK_LARGE     9'h1ff
`define PAGE_MASK_8    4'h7
`define PAGE_MASK_16   4'hf
`define PAGE_SLOTS     16
// Slave address byte fields
`define SA_TYPE        7:4
`define SA_SEL3        3:1
`define SA_SEL2        3:2
`define SA_PS          1
`define SA_RW          0
`define DIR_READ       1'b1
`define TYPE_CODE_DFLT 4'h5
`define BYTE_BITS      4'h8
// Pin bundle idle level: clock, data, protect high
`define PIN_IDLE       6'h38
// Programming time
`define T_WR_US        10000
`define CLK_MHZ        20
`define WR_CYC         (`T_WR_US * `CLK_MHZ)
`define PROG_W         18
`endif

// ### eeprom_pkg.sv
// Types shared by the serial EEPROM slave modules
`include "eeprom_defs.svh"
package eeprom_pkg;
    // Pins as seen from outside, before synchronising
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [2:0] sel;
    } pin_in_t;
    // One array write
    typedef struct packed {
        logic                en;
        logic [`ADDR_W-1:0]  addr;
        logic [7:0]          data;
    } mem_wr_t;
    // Bus command phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_WADR = 3'h2,
        ST_WDAT = 3'h3,
        ST_RDAT = 3'h4,
        ST_IGN  = 3'h5
    } bus_st_t;
    // Whole slave state
    typedef struct packed {
        bus_st_t                     st;
        logic                        scl_d;
        logic                        sda_d;
        logic [3:0]                  bit_cnt;
        logic [7:0]                  rx;
        logic [7:0]                  tx;
        logic                        ack_req;
        logic                        sda_oe;
        logic                        sda_lvl;
        logic [`ADDR_W-1:0]          addr_ctr;
        logic [`ADDR_W-1:0]          page_base;
        logic [3:0]                  wr_off;
        logic [`PAGE_SLOTS-1:0]      wr_valid;
        logic [`PAGE_SLOTS-1:0][7:0] page_buf;
        logic                        busy;
        logic [`PROG_W-1:0]          prog_cnt;
    } slave_st_t;
    // Synchroniser stages
    typedef struct packed {
        pin_in_t meta;
        pin_in_t sync;
    } sync_st_t;
endpackage

// ### pin_sync.sv
// Two-stage synchroniser for the bus and strap pins
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_defs.svh"
module pin_sync
    import eeprom_pkg::*;
(
    input  wire logic    core_clk_i,
    input  wire logic    rst_n_i,
    input  wire pin_in_t pins_i,
    output var  pin_in_t pins_o
);
    sync_st_t cur_reg;   // Both stages
    sync_st_t cur_next;  // Next value

    // Second stage reads only the first
    always_comb begin
        cur_next      = cur_reg;
        cur_next.meta = pins_i;
        cur_next.sync = cur_reg.meta;
    end

    // Reset to an idle bus so no false start appears
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_reg <= {`PIN_IDLE, `PIN_IDLE};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign pins_o = cur_reg.sync;
endmodule
`default_nettype wire

// ### cell_array.sv
// Byte array standing in for the memory cells
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_defs.svh"
module cell_array
    import eeprom_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire mem_wr_t            wr_i,
    input  wire logic [`ADDR_W-1:0] rd_addr_i,
    output logic      [7:0]         rd_data_o
);
    logic [7:0] mem [`MEM_DEPTH];  // Cell contents, no reset

    // Writes land on the clock edge
    always_ff @(posedge core_clk_i) begin
        if (wr_i.en) begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end

    // Read is combinational so a new address is usable at once
    assign rd_data_o = mem[rd_addr_i];
endmodule
`default_nettype wire

// ### eeprom_slave.sv
// Two-wire serial EEPROM slave: decode, acknowledge, page buffer, commit
// Behaviour
// - No command runs before a start
// - Stop completes the running command
// - Sample on clock rise, drive after fall
// - Write data programmed only after stop
// - Upper four address bits must match type
// - Small variants compare three select pins
// - Lowest bit: zero writes, one reads
// - Large variant compares two select pins
// - Page-select bit is top memory address bit
// - Write protect high blocks all programming
// - Byte sender releases data line afterwards
// - Receiver pulls data low on ninth clock
// - Acknowledge a matching slave address
// - Acknowledge every word address and data byte
// - Master acknowledge continues with next byte
// - No acknowledge: release, wait stop, standby
// - Byte write lands at the word address
// - Smallest variant pages eight bytes
// - Middle variant pages eight bytes
// - Largest variant pages sixteen bytes
// - After reads counter points past last
// - After writes counter stays at last written
// - Random read loads address, then reads
// - Current read with no acknowledge gives one byte
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_defs.svh"
module eeprom_slave
    import eeprom_pkg::*;
#(
    parameter logic [1:0]  variant   = `VAR_LARGE,      // Array size and page shape
    parameter logic [3:0]  type_code = `TYPE_CODE_DFLT, // Arbitrary value
    parameter int unsigned wr_cycles = `WR_CYC          // Programming time in clocks
)(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic write_protect_i,
    input  wire logic device_select_pin_0_i,
    input  wire logic device_select_pin_1_i,
    input  wire logic device_select_pin_2_i,
    output var  logic sda_o,
    output var  logic sda_oe_o,
    output var  logic busy_o
);
    // Size of the array and of one page
    localparam logic [`ADDR_W-1:0] addr_mask =
        (variant == `VAR_SMALL) ? `MASK_SMALL :
        (variant == `VAR_MID)   ? `MASK_MID   : `MASK_LARGE;
    localparam logic [3:0] page_mask =
        (variant == `VAR_LARGE) ? `PAGE_MASK_16 : `PAGE_MASK_8;
    localparam logic [`PROG_W-1:0] prog_last = `PROG_W'(wr_cycles - 1);

    slave_st_t          cur_reg;   // Registered state
    slave_st_t          cur_next;  // Next state
    pin_in_t            pins_raw;  // Pins before synchronising
    pin_in_t            pins_s;    // Pins after two flops
    mem_wr_t            wr;        // Array write from commit
    logic [`ADDR_W-1:0] rd_addr;   // Array read address
    logic [7:0]         rd_data;   // Byte at rd_addr
    logic               scl_s;     // Synced clock line
    logic               sda_s;     // Synced data line
    logic               wp_s;      // Synced write protect
    logic               rise_ev;   // Clock line rose
    logic               fall_ev;   // Clock line fell
    logic               start_ev;  // Data fell, clock high
    logic               stop_ev;   // Data rose, clock high
    logic [7:0]         rxb;       // Byte including current bit

    assign pins_raw = '{scl: scl_i, sda: sda_i, wp: write_protect_i,
                        sel: {device_select_pin_2_i, device_select_pin_1_i,
                              device_select_pin_0_i}};

    // All pins are asynchronous to the core clock
    pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pins_i     (pins_raw),
        .pins_o     (pins_s)
    );

    cell_array u_cells (
        .core_clk_i (core_clk_i),
        .wr_i       (wr),
        .rd_addr_i  (rd_addr),
        .rd_data_o  (rd_data)
    );

    assign scl_s = pins_s.scl;
    assign sda_s = pins_s.sda;
    assign wp_s  = pins_s.wp;

    // Bus edges from the synced lines and their last values
    assign rise_ev  = scl_s & ~cur_reg.scl_d;
    assign fall_ev  = ~scl_s & cur_reg.scl_d;
    assign start_ev = scl_s & cur_reg.scl_d & cur_reg.sda_d & ~sda_s;
    assign stop_ev  = scl_s & cur_reg.scl_d & ~cur_reg.sda_d & sda_s;
    assign rxb      = {cur_reg.rx[6:0], sda_s};

    // Page bit arrives one bit before the address ends, so the large
    // variant reads through it while the slave address is still coming
    always_comb begin
        if (cur_reg.st == ST_DEV && variant == `VAR_LARGE) begin
            rd_addr = {cur_reg.rx[0], cur_reg.addr_ctr[7:0]};
        end else begin
            rd_addr = cur_reg.addr_ctr;
        end
    end

    // Type code and select pins against a full address byte
    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
        logic sel_ok;
        if (variant == `VAR_LARGE) begin
            sel_ok = (b[`SA_SEL2] == sel[2:1]);
        end else begin
            sel_ok = (b[`SA_SEL3] == sel);
        end
        return (b[`SA_TYPE] == type_code) && sel_ok;
    endfunction

    // Next state: commit engine, then bus events by priority
    always_comb begin
        cur_next       = cur_reg;
        cur_next.scl_d = scl_s;
        cur_next.sda_d = sda_s;
        wr             = '0;
        // Programming walks the page buffer, then waits out the cycle
        if (cur_reg.busy) begin
            if (cur_reg.prog_cnt < `PROG_W'(`PAGE_SLOTS)) begin
                wr.en   = cur_reg.wr_valid[cur_reg.prog_cnt[3:0]];
                wr.addr = cur_reg.page_base | {5'h0, cur_reg.prog_cnt[3:0]};
                wr.data = cur_reg.page_buf[cur_reg.prog_cnt[3:0]];
            end
            if (cur_reg.prog_cnt >= prog_last) begin
                cur_next.busy     = 1'b0;
                cur_next.prog_cnt = '0;
                cur_next.wr_valid = '0;
            end else begin
                cur_next.prog_cnt = cur_reg.prog_cnt + 1'b1;
            end
        end
        if (start_ev) begin
            // Also a repeated start; an unstopped write is dropped
            cur_next.st      = ST_DEV;
            cur_next.bit_cnt = '0;
            cur_next.ack_req = 1'b0;
            cur_next.sda_oe  = 1'b0;
            if (!cur_reg.busy) begin
                cur_next.wr_valid = '0;
            end
        end else if (stop_ev) begin
            // Stop commits buffered data unless protected
            if (cur_reg.st == ST_WDAT && |cur_reg.wr_valid && !wp_s
                    && !cur_reg.busy) begin
                cur_next.busy     = 1'b1;
                cur_next.prog_cnt = '0;
            end else if (!cur_reg.busy) begin
                cur_next.wr_valid = '0;
            end
            cur_next.st      = ST_IDLE;
            cur_next.sda_oe  = 1'b0;
            cur_next.ack_req = 1'b0;
        end else if (rise_ev) begin
            if (cur_reg.bit_cnt == `BYTE_BITS) begin
                // Ninth clock: our acknowledge ends, or master's is sampled
                cur_next.bit_cnt = '0;
                if (cur_reg.ack_req) begin
                    cur_next.ack_req = 1'b0;
                end else if (cur_reg.st == ST_RDAT) begin
                    if (!sda_s) begin
                        // Next byte, counter moves past it
                        cur_next.tx       = rd_data;
                        cur_next.addr_ctr = (cur_reg.addr_ctr + 1'b1) & addr_mask;
                    end else begin
                        cur_next.st = ST_IGN;
                    end
                end
            end else if (cur_reg.st == ST_RDAT) begin
                // Master sampled a bit; present the next one
                cur_next.tx      = {cur_reg.tx[6:0], 1'b0};
                cur_next.bit_cnt = cur_reg.bit_cnt + 1'b1;
            end else if (cur_reg.st inside {ST_DEV, ST_WADR, ST_WDAT}) begin
                cur_next.rx      = rxb;
                cur_next.bit_cnt = cur_reg.bit_cnt + 1'b1;
                if (cur_reg.bit_cnt == `BYTE_BITS - 4'h1) begin
                    case (cur_reg.st)
                        ST_DEV: begin
                            // First byte after start is the slave address
                            if (dev_match(rxb, pins_s.sel) && !cur_reg.busy) begin
                                cur_next.ack_req = 1'b1;
                                if (variant == `VAR_LARGE) begin
                                    cur_next.addr_ctr[8] = rxb[`SA_PS];
                                end
                                if (rxb[`SA_RW] == `DIR_READ) begin
                                    // Current or random read: counter past byte
                                    cur_next.st       = ST_RDAT;
                                    cur_next.tx       = rd_data;
                                    cur_next.addr_ctr = (rd_addr + 1'b1) & addr_mask;
                                end else begin
                                    cur_next.st = ST_WADR;
                                end
                            end else begin
                                cur_next.st = ST_IGN;
                            end
                        end
                        ST_WADR: begin
                            // Word address loads the counter for reads too
                            cur_next.addr_ctr  = {cur_reg.addr_ctr[8], rxb} & addr_mask;
                            cur_next.page_base = {cur_reg.addr_ctr[8], rxb} & addr_mask
                                                 & ~{5'h0, page_mask};
                            cur_next.wr_off    = rxb[3:0] & page_mask;
                            cur_next.wr_valid  = '0;
                            cur_next.ack_req   = 1'b1;
                            cur_next.st        = ST_WDAT;
                        end
                        ST_WDAT: begin
                            // Buffered until stop; offset wraps inside page
                            cur_next.page_buf[cur_reg.wr_off] = rxb;
                            cur_next.wr_valid[cur_reg.wr_off] = 1'b1;
                            cur_next.addr_ctr = cur_reg.page_base
                                                | {5'h0, cur_reg.wr_off};
                            cur_next.wr_off   = (cur_reg.wr_off + 4'h1) & page_mask;
                            cur_next.ack_req  = 1'b1;
                        end
                        default: begin
                            cur_next.st = ST_IGN;
                        end
                    endcase
                end
            end
        end else if (fall_ev) begin
            // Line changes only after a falling clock
            if (cur_reg.bit_cnt == `BYTE_BITS) begin
                cur_next.sda_oe = cur_reg.ack_req;
            end else if (cur_reg.st == ST_RDAT) begin
                cur_next.sda_oe = ~cur_reg.tx[7];
            end else begin
                cur_next.sda_oe = 1'b0;
            end
        end
    end

    // Single state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_reg       <= '0;
            cur_reg.scl_d <= 1'b1;
            cur_reg.sda_d <= 1'b1;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Open drain: level is always low, enable does the work
    assign sda_o    = cur_reg.sda_lvl;
    assign sda_oe_o = cur_reg.sda_oe;
    assign busy_o   = cur_reg.busy;

    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_dev_done;
        rise_ev && cur_reg.st == ST_DEV && cur_reg.bit_cnt == `BYTE_BITS - 4'h1;
    endsequence
    sequence s_master_slot;
        rise_ev && cur_reg.st == ST_RDAT && cur_reg.bit_cnt == `BYTE_BITS
            && !cur_reg.ack_req;
    endsequence
    sequence s_data_done;
        rise_ev && cur_reg.st == ST_WDAT && cur_reg.bit_cnt == `BYTE_BITS - 4'h1;
    endsequence
    sequence s_wadr_done;
        rise_ev && cur_reg.st == ST_WADR && cur_reg.bit_cnt == `BYTE_BITS - 4'h1;
    endsequence

    chk_idle_waits_start: assert property (
        cur_reg.st == ST_IDLE && !start_ev |=> cur_reg.st == ST_IDLE)
        else $error("left idle without start");
    chk_stop_ends_cmd: assert property (
        stop_ev |=> cur_reg.st == ST_IDLE && !cur_reg.sda_oe)
        else $error("stop did not end command");
    chk_drive_after_fall: assert property (
        $rose(cur_reg.sda_oe) |-> $past(fall_ev))
        else $error("data driven off a falling clock");
    chk_commit_on_stop: assert property (
        $rose(cur_reg.busy) |-> $past(stop_ev) && !$past(wp_s))
        else $error("programming without stop or while protected");
    chk_type_reject: assert property (
        s_dev_done ##0 (cur_reg.rx[6:3] != type_code) |=> cur_reg.st == ST_IGN)
        else $error("foreign type code accepted");
    chk_busy_no_ack: assert property (
        s_dev_done ##0 cur_reg.busy |=> cur_reg.st == ST_IGN && !cur_reg.ack_req)
        else $error("address acknowledged while programming");
    chk_ack_drives_low: assert property (
        fall_ev && cur_reg.ack_req && cur_reg.bit_cnt == `BYTE_BITS
        |=> cur_reg.sda_oe [*2])
        else $error("acknowledge not driven");
    chk_nack_release: assert property (
        s_master_slot ##0 sda_s |=> cur_reg.st == ST_IGN && !cur_reg.sda_oe)
        else $error("read continued after no acknowledge");
    chk_read_advance: assert property (
        s_master_slot ##0 !sda_s
        |=> cur_reg.addr_ctr == ((`ADDR_W'($past(cur_reg.addr_ctr) + 1'b1)) & addr_mask))
        else $error("read counter did not advance");
    chk_write_ctr_hold: assert property (
        s_data_done |=> cur_reg.addr_ctr
            == ($past(cur_reg.page_base) | {5'h0, $past(cur_reg.wr_off)}))
        else $error("write counter not at last written byte");
    chk_protect_blocks: assert property (
        stop_ev && wp_s && !cur_reg.busy |=> !cur_reg.busy)
        else $error("programming started while protected");
    chk_unstopped_drop: assert property (
        start_ev && !cur_reg.busy |=> cur_reg.wr_valid == '0)
        else $error("unstopped write data kept");
    chk_byte_release: assert property (
        fall_ev && cur_reg.bit_cnt == `BYTE_BITS && !cur_reg.ack_req |=> !cur_reg.sda_oe)
        else $error("data line held after a sent byte");
    chk_byte_lands: assert property (
        s_data_done |=> cur_reg.page_buf[cur_reg.addr_ctr[3:0] & page_mask] == $past(rxb))
        else $error("data byte not buffered at its address");
    chk_page_wrap: assert property (
        s_data_done ##0 (cur_reg.wr_off == page_mask) |=> cur_reg.wr_off == '0)
        else $error("page offset did not wrap");
    chk_read_wrap: assert property (
        s_master_slot ##0 (!sda_s && cur_reg.addr_ctr == addr_mask)
        |=> cur_reg.addr_ctr == '0)
        else $error("read counter did not wrap to zero");
    chk_random_load: assert property (
        s_wadr_done |=> cur_reg.addr_ctr[7:0] == ($past(rxb) & addr_mask[7:0]))
        else $error("word address not loaded");
endmodule
`default_nettype wire

// ### i2c_master_model.sv
// Behavioural two-wire bus master that drives the EEPROM slave's far side
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    input  wire logic core_clk_i,
    input  wire logic sda_wire_i,
    output var  logic scl_o,
    output var  logic sda_drv_o
);
    // Both lines released high while the bus is idle
    initial begin
        scl_o     = 1'b1;
        sda_drv_o = 1'b1;
    end
    // Every change lands just after a core clock edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // Start or repeated start; the clock stands high between frames
    task automatic start();
        sda_drv_o <= 1'b1;
        wait_clk(2);
        scl_o <= 1'b1;
        wait_clk(4);
        sda_drv_o <= 1'b0;
        wait_clk(4);
        scl_o <= 1'b0;
        wait_clk(2);
    endtask
    // Stop; the clock is left high afterwards
    task automatic stop();
        sda_drv_o <= 1'b0;
        wait_clk(2);
        scl_o <= 1'b1;
        wait_clk(4);
        sda_drv_o <= 1'b1;
        wait_clk(4);
    endtask
    // One 400 ns bit: data set in the low phase, wire sampled late in the high phase
    task automatic bit_cycle(input logic v, output logic s);
        sda_drv_o <= v;
        wait_clk(2);
        scl_o <= 1'b1;
        wait_clk(4);
        s = sda_wire_i;
        scl_o <= 1'b0;
        wait_clk(2);
    endtask
    // Byte out, most significant bit first, then release for the answer
    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, ack_n);
    endtask
    // Byte in; low answer asks for more, high ends the read
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b = {b[6:0], s};
        end
        bit_cycle(last, s);
    endtask
endmodule
`default_nettype wire

// ### eeprom_slave_test.sv
// Self-checking bench for the serial EEPROM slave, large variant
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave_test;
    localparam logic [3:0] dev_type = 4'h6; // Arbitrary type code
    localparam logic [1:0] sel_ok   = 2'b10; // Straps pin 2 high, pin 1 low
    logic       core_clk = 1'b0;
    logic       rst_n    = 1'b0;
    logic       write_protect = 1'b0;
    logic [2:0] sel_pins = 3'b101; // Select straps, pin 2 down to pin 0
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe;
    logic       busy;
    wire        sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1); // Pull-up wire
    int         num_errors = 0;
    int         checked    = 0;
    logic       ack;
    logic [7:0] rd;
    // 20 MHz core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    eeprom_slave #(.variant(2'h2), .type_code(dev_type), .wr_cycles(200)) dut_u (
        .core_clk_i            (core_clk),
        .rst_n_i               (rst_n),
        .scl_i                 (scl),
        .sda_i                 (sda_wire),
        .write_protect_i       (write_protect),
        .device_select_pin_0_i (sel_pins[0]),
        .device_select_pin_1_i (sel_pins[1]),
        .device_select_pin_2_i (sel_pins[2]),
        .sda_o                 (sda_out),
        .sda_oe_o              (sda_oe),
        .busy_o                (busy)
    );
    i2c_master_model master_u (
        .core_clk_i (core_clk),
        .sda_wire_i (sda_wire),
        .scl_o      (scl),
        .sda_drv_o  (sda_drv)
    );
    // Count and report one comparison
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Start followed by the slave address byte
    task automatic send_addr(input logic ps, input logic rdir, input logic [1:0] sel);
        master_u.start();
        master_u.wr_byte({dev_type, sel, ps, rdir}, ack);
    endtask
    // Load the address counter; both bytes must be answered low
    task automatic set_ptr(input logic [8:0] a);
        send_addr(a[8], 1'b0, sel_ok);
        check({7'h00, ack}, 8'h00, "slave ack");
        master_u.wr_byte(a[7:0], ack);
        check({7'h00, ack}, 8'h00, "word ack");
    endtask
    // Bounded wait for the programming cycle to end
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
            master_u.wait_clk(1);
        end
        check({7'h00, busy}, 8'h00, "busy end");
    endtask
    // Byte or page write closed by a stop
    task automatic write_bytes(input logic [8:0] a, input logic [7:0] d[$]);
        set_ptr(a);
        foreach (d[i]) begin
            master_u.wr_byte(d[i], ack);
            check({7'h00, ack}, 8'h00, "data ack");
        end
        check({7'h00, busy}, 8'h00, "busy before stop");
        master_u.stop();
        check({7'h00, busy}, {7'h00, ~write_protect}, "busy after stop");
        wait_idle();
    endtask
    // Read from the counter, low answer on all but the last byte
    task automatic read_seq(input logic ps, input logic [7:0] exp[$]);
        send_addr(ps, 1'b1, sel_ok);
        check({7'h00, ack}, 8'h00, "read ack");
        foreach (exp[i]) begin
            master_u.rd_byte(i == exp.size() - 1, rd);
            check(rd, exp[i], "read data");
        end
        master_u.stop();
        check({7'h00, sda_oe}, 8'h00, "released");
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 5000 clocks
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        master_u.wait_clk(4);
        send_addr(1'b0, 1'b0, sel_ok);
        check({7'h00, ack}, 8'h00, "match ack");
        master_u.stop();
        master_u.start();
        master_u.wr_byte({~dev_type, sel_ok, 2'b00}, ack);
        check({7'h00, ack}, 8'h01, "type refused");
        master_u.stop();
        send_addr(1'b0, 1'b0, ~sel_ok);
        check({7'h00, ack}, 8'h01, "select refused");
        master_u.stop();
        sel_pins <= 3'b100;
        send_addr(1'b0, 1'b0, sel_ok);
        check({7'h00, ack}, 8'h00, "pin 0 ignored");
        master_u.stop();
        sel_pins <= 3'b010;
        send_addr(1'b0, 1'b0, 2'b01);
        check({7'h00, ack}, 8'h00, "moved straps ack");
        master_u.stop();
        send_addr(1'b0, 1'b0, sel_ok);
        check({7'h00, ack}, 8'h01, "old straps refused");
        master_u.stop();
        sel_pins <= 3'b101;
        $display("test addressing done");
        write_protect <= 1'b0;
        set_ptr(9'h000);
        master_u.wr_byte(8'ha5, ack);
        master_u.stop();
        send_addr(1'b0, 1'b0, sel_ok);
        check({7'h00, ack}, 8'h01, "busy refused");
        master_u.stop();
        wait_idle();
        read_seq(1'b0, '{8'ha5});
        $display("test byte write done");
        set_ptr(9'h000);
        master_u.wr_byte(8'h77, ack);
        set_ptr(9'h000);
        read_seq(1'b0, '{8'ha5});
        $display("test no stop done");
        write_bytes(9'h10d, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
        set_ptr(9'h100);
        read_seq(1'b1, '{8'h44});
        read_seq(1'b1, '{8'h55});
        set_ptr(9'h10e);
        read_seq(1'b1, '{8'h22, 8'h33});
        $display("test page write done");
        write_bytes(9'h1fe, '{8'hc3, 8'h5a});
        set_ptr(9'h1fe);
        read_seq(1'b1, '{8'hc3, 8'h5a, 8'ha5});
        $display("test wrap done");
        write_protect <= 1'b1;
        write_bytes(9'h000, '{8'h00});
        write_protect <= 1'b0;
        set_ptr(9'h000);
        read_seq(1'b0, '{8'ha5});
        $display("test write protect done");
        complete_run();
    end
endmodule
`default_nettype wire
